//--- logic/cstx_out_ctl.sv
// Transmitter output control: rate, replicate, pin state, buffers, status.
`timescale 1ns/10ps

// How it works
// R1: Rate code 11b selects 400 Mbps, software timing.
// R2: 800M and 1.6G load timing values automatically.
// R3: Host writes timing and sets override bit.
// R4: Replicate copies port 0 output onto port 1.
// R5: Replicate turns on second clock lane.
// R6: Host limits lanes to one or two.
// R7: Sleep select 0 forces HS-0 outputs.
// R8: Pin drive enable 0 gives high impedance.
// R9: Normal mode follows mapped receive port activity.
// R10: All inactive, choice 0: high impedance.
// R11: Choice 1 inactive, or disabled: LP-11.
// R12: Active means any mapped port is locked.
// R13: Pass flag only while valid data flows.
// R14: Sync flag zero without synchronized forwarding.
// R15: Status on a pin, change pulse raised.
// R16: One 16 kB buffer per receive port.
// R17: Pull a packet only once fully stored.
// R18: Count received lines, high byte first.
// R19: Measure line bytes, high byte first.
// R20: Figures valid only for single stream.
// R21: Four rates chosen by two-bit field.
// R22: Transmit enable gives LP-11 by default.
// R23: Power-down, sleep, drive, activity priority.
module cstx_out_ctl
   import cstx_pkg::*;
(
   // Clock and reset.
   input  wire logic                  core_clk,
   input  wire logic                  nrst,
   // Pins from outside the clock domain.
   input  wire logic                  power_down_pin_n,
   input  wire logic [NPORT-1:0]      rx_lock,
   // Register port.
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [7:0]            reg_rdata,
   // Receive streams, one byte per cycle per port.
   input  wire logic [NPORT-1:0]      rx_valid,
   input  wire logic [NPORT-1:0][7:0] rx_data,
   input  wire logic [NPORT-1:0]      rx_last,
   input  wire logic [NPORT-1:0]      rx_err,
   output logic      [NPORT-1:0]      rx_ready,
   // Transmitter outputs.
   output cstx_pin_e                  pin_state,
   output logic      [7:0]            tx0_data,
   output logic                       tx0_valid,
   output logic      [7:0]            tx1_data,
   output logic                       tx1_valid,
   output logic                       tx1_clk_en,
   output logic      [1:0]            tx_lanes,
   output logic      [1:0]            tx_rate,
   output logic      [7:0]            tx_timing,
   // Status outputs.
   output logic                       status_gpio,
   output logic                       status_change
);
   // ----------------------------------------------------------------
   // Pin synchronisers.
   // ----------------------------------------------------------------
   logic             pd_s1_r, pd_s2_r;     // Power-down pin stages.
   logic [NPORT-1:0] lock_s1_r, lock_s2_r; // Lock stages.

   // Power-down resets to asserted so pins start in high impedance.
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         pd_s1_r   <= 1'b0;
         pd_s2_r   <= 1'b0;
         lock_s1_r <= '0;
         lock_s2_r <= '0;
      end
      else
      begin
         pd_s1_r   <= power_down_pin_n;
         pd_s2_r   <= pd_s1_r;
         lock_s1_r <= rx_lock;
         lock_s2_r <= lock_s1_r;
      end

   // ----------------------------------------------------------------
   // Configuration registers.
   // ----------------------------------------------------------------
   logic [7:0] gen_cfg_r;   // Sleep select, drive enable, inactive choice.
   logic [7:0] rate_r;      // Rate code and override.
   logic [7:0] fwd_port_r;  // Port map and forward disables.
   logic [7:0] fwd_mode_r;  // Replicate and synchronized forwarding.
   logic [7:0] tx_ctl_r;    // Transmit enable and lane quantity.
   logic [7:0] timing_r;    // Programmed lane timing value.

   // Plain stores; each register steers logic below.
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         gen_cfg_r  <= RST_GEN_CFG;
         rate_r     <= RST_ZERO;
         fwd_port_r <= RST_FWD_PORT;
         fwd_mode_r <= RST_ZERO;
         tx_ctl_r   <= RST_ZERO;
         timing_r   <= RST_ZERO;
      end
      else if (reg_wr)
      begin
         if (reg_addr == ADDR_GEN_CFG)  gen_cfg_r  <= reg_wdata;
         if (reg_addr == ADDR_RATE)     rate_r     <= reg_wdata;
         if (reg_addr == ADDR_FWD_PORT) fwd_port_r <= reg_wdata;
         if (reg_addr == ADDR_FWD_MODE) fwd_mode_r <= reg_wdata;
         if (reg_addr == ADDR_TX_CTL)   tx_ctl_r   <= reg_wdata;
         if (reg_addr == ADDR_TIMING)   timing_r   <= reg_wdata;
      end

   // Named control fields.
   wire             cfg_sleep  = gen_cfg_r[B_SLEEP_SEL];
   wire             cfg_drive  = gen_cfg_r[B_PIN_DRIVE];
   wire             cfg_lp11   = gen_cfg_r[B_INACT_LP11];
   wire             cfg_ovr    = rate_r[B_OVERRIDE];
   wire [1:0]       cfg_rate   = rate_r[1:0];
   wire [NPORT-1:0] cfg_map    = fwd_port_r[F_MAP_LO +: NPORT];
   wire [NPORT-1:0] cfg_dis    = fwd_port_r[F_DIS_LO +: NPORT];
   wire             cfg_repl   = fwd_mode_r[B_REPLICATE];
   wire             cfg_sync   = fwd_mode_r[B_SYNC_FWD];
   wire             cfg_tx_en  = tx_ctl_r[B_TX_EN];

   // ----------------------------------------------------------------
   // Lane rate and timing selection.
   // ----------------------------------------------------------------
   // Override wins; otherwise 800M and 1.6G use built-in values and
   // other codes fall back to a default that software must replace.
   wire [7:0] timing_auto = (cfg_rate == RATE_1G6) ? TIM_1G6 :   // R2
                            (cfg_rate == RATE_800) ? TIM_800 :   // R2
                            TIM_DFLT;                            // R1
   wire [7:0] timing_sel  = cfg_ovr ? timing_r : timing_auto;     // R3

   // ----------------------------------------------------------------
   // Output pin state.
   // ----------------------------------------------------------------
   wire [NPORT-1:0] mapped_lock = lock_s2_r & cfg_map;
   wire             any_active  = |mapped_lock;                   // R12
   // Forwarding counts as off when every locked mapped port is disabled.
   wire             fwd_off     = &(cfg_dis | ~mapped_lock);
   cstx_pin_e       pin_nxt;

   // Priority: power-down, sleep select, drive enable, activity.
   always_comb
   begin
      if (!pd_s2_r)                  pin_nxt = PIN_HIZ;    // R23
      else if (!cfg_sleep)           pin_nxt = PIN_HS0;    // R7
      else if (!cfg_drive)           pin_nxt = PIN_HIZ;    // R8
      else if (!any_active)                                // R9
         pin_nxt = cfg_lp11 ? PIN_LP11 : PIN_HIZ;          // R10 R11
      else if (fwd_off || !cfg_tx_en) pin_nxt = PIN_LP11;   // R11 R22
      else                           pin_nxt = PIN_VALID;
   end

   // ----------------------------------------------------------------
   // Video buffers, one per receive port.
   // ----------------------------------------------------------------
   logic [NPORT-1:0][8:0]       rd_word;  // Byte and last flag at head.
   logic [NPORT-1:0][CNT_W-1:0] pkt_cnt;  // Whole packets held.
   logic [NPORT-1:0]            rd_adv;   // Forwarder takes one byte.

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++)
      begin : g_buf
         logic [8:0]       mem [BUF_DEPTH];  // 16 kB payload plus flags. // R16
         logic [PTR_W-1:0] wr_ptr_r, rd_ptr_r;
         logic [CNT_W-1:0] fill_r, pkt_r;
         logic             rdy_r;
         wire              wr_en   = rx_valid[gp] & rdy_r;
         wire              wr_end  = wr_en & rx_last[gp];
         wire              rd_end  = rd_adv[gp] & mem[rd_ptr_r][8];
         wire [CNT_W-1:0]  fill_nxt = fill_r + CNT_W'(wr_en) - CNT_W'(rd_adv[gp]);

         // Storage only; no reset needed on the array.
         always_ff @(posedge core_clk)
            if (wr_en)
               mem[wr_ptr_r] <= {rx_last[gp], rx_data[gp]};

         // Pointers, fill level and whole-packet count.
         always_ff @(posedge core_clk or negedge nrst)
            if (!nrst)
            begin
               wr_ptr_r <= '0;
               rd_ptr_r <= '0;
               fill_r   <= '0;
               pkt_r    <= '0;
               rdy_r    <= 1'b0;
            end
            else
            begin
               wr_ptr_r <= wr_ptr_r + PTR_W'(wr_en);
               rd_ptr_r <= rd_ptr_r + PTR_W'(rd_adv[gp]);
               fill_r   <= fill_nxt;
               // A packet counts only once its last byte is in. // R17
               pkt_r    <= pkt_r + CNT_W'(wr_end) - CNT_W'(rd_end);
               rdy_r    <= fill_nxt < CNT_W'(BUF_DEPTH);
            end

         assign rd_word[gp]  = mem[rd_ptr_r];
         assign pkt_cnt[gp]  = pkt_r;
         assign rx_ready[gp] = rdy_r;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Forwarding engine: round robin over ports with a whole packet.
   // ----------------------------------------------------------------
   cstx_fw_e fw_state_r;          // Idle or sending a packet.
   logic     sel_r;               // Port being forwarded.
   logic     rr_r;                // Port favoured next.
   logic     tx0_valid_r, tx1_valid_r, tx1_clk_r;
   logic [7:0] tx0_data_r, tx1_data_r;

   wire [NPORT-1:0] pkt_ready;
   generate
      for (gp = 0; gp < NPORT; gp++)
      begin : g_rdy
         assign pkt_ready[gp] = (pkt_cnt[gp] != '0) & cfg_map[gp] & ~cfg_dis[gp];
      end
   endgenerate
   wire sending = (pin_state == PIN_VALID);
   wire pick    = pkt_ready[rr_r] ? rr_r : ~rr_r;
   wire fw_go   = (fw_state_r == FW_IDLE) & sending & |pkt_ready;  // R17
   wire fw_busy = (fw_state_r == FW_SEND);
   wire [8:0] head = rd_word[sel_r];
   assign rd_adv = fw_busy ? (NPORT'(1) << sel_r) : '0;

   // One byte per cycle until the flagged last byte goes out.
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         fw_state_r <= FW_IDLE;
         sel_r      <= 1'b0;
         rr_r       <= 1'b0;
      end
      else if (fw_go)
      begin
         fw_state_r <= FW_SEND;
         sel_r      <= pick;
      end
      else if (fw_busy && head[8])
      begin
         fw_state_r <= FW_IDLE;
         rr_r       <= ~sel_r;
      end

   // Port 1 mirrors port 0 in replicate mode and gets its own clock.
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         tx0_data_r  <= '0;
         tx0_valid_r <= 1'b0;
         tx1_data_r  <= '0;
         tx1_valid_r <= 1'b0;
         tx1_clk_r   <= 1'b0;
      end
      else
      begin
         tx0_data_r  <= head[7:0];
         tx0_valid_r <= fw_busy;
         tx1_data_r  <= cfg_repl ? head[7:0] : '0;      // R4
         tx1_valid_r <= cfg_repl & fw_busy;             // R4
         tx1_clk_r   <= cfg_repl;                       // R5
      end

   // ----------------------------------------------------------------
   // Status flags and pin-facing registered outputs.
   // ----------------------------------------------------------------
   logic       pass_r, sync_r, chg_r;
   cstx_pin_e  pin_r;
   logic [1:0] lanes_r, rate_o_r;
   logic [7:0] tim_o_r;
   wire        pass_nxt = fw_busy & sending & ~|rx_err;             // R13
   // Aligned when both ports locked and both hold a whole packet.
   wire        sync_nxt = cfg_sync & (&mapped_lock) & (&pkt_ready); // R14

   // Change pulse lets a host interrupt on any status edge.
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         pass_r   <= 1'b0;
         sync_r   <= 1'b0;
         chg_r    <= 1'b0;
         pin_r    <= PIN_HIZ;
         lanes_r  <= '0;
         rate_o_r <= '0;
         tim_o_r  <= '0;
      end
      else
      begin
         pass_r   <= pass_nxt;
         sync_r   <= sync_nxt;
         chg_r    <= (pass_nxt != pass_r) | (sync_nxt != sync_r);  // R15
         pin_r    <= pin_nxt;
         // The lane count passes through; replicate needs one or two.
         lanes_r  <= tx_ctl_r[F_LANES_LO +: 2];
         rate_o_r <= cfg_rate;                                    // R21
         tim_o_r  <= timing_sel;
      end

   // ----------------------------------------------------------------
   // Line count and line length on receive port 0.
   // ----------------------------------------------------------------
   // Mixed virtual channels on one port blur these figures. // R20
   logic [15:0] line_cnt_r, line_len_r, len_acc_r;
   logic [7:0]  cnt_lo_r, len_lo_r;  // Low bytes caught on high read.
   wire         w0     = rx_valid[0] & rx_ready[0];
   wire         w0_end = w0 & rx_last[0];

   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         line_cnt_r <= '0;
         line_len_r <= '0;
         len_acc_r  <= '0;
      end
      else if (w0_end)
      begin
         line_cnt_r <= line_cnt_r + 16'h0001;                // R18
         line_len_r <= len_acc_r + 16'h0001;                 // R19
         len_acc_r  <= '0;
      end
      else if (w0)
         len_acc_r  <= len_acc_r + 16'h0001;

   // ----------------------------------------------------------------
   // Register read path.
   // ----------------------------------------------------------------
   // Reading the high byte freezes the low byte so a pair reads whole.
   wire [7:0] status_v = {6'h00, sync_r, pass_r};
   wire [7:0] rd_mux  =
      (reg_addr == ADDR_GEN_CFG)  ? gen_cfg_r  :
      (reg_addr == ADDR_RATE)     ? rate_r     :
      (reg_addr == ADDR_FWD_PORT) ? fwd_port_r :
      (reg_addr == ADDR_FWD_MODE) ? fwd_mode_r :
      (reg_addr == ADDR_TX_CTL)   ? tx_ctl_r   :
      (reg_addr == ADDR_TIMING)   ? timing_r   :
      (reg_addr == ADDR_STATUS)   ? status_v   :
      (reg_addr == ADDR_LINES_HI) ? line_cnt_r[15:8] :  // R18
      (reg_addr == ADDR_LINES_LO) ? cnt_lo_r   :
      (reg_addr == ADDR_LEN_HI)   ? line_len_r[15:8] :  // R19
      (reg_addr == ADDR_LEN_LO)   ? len_lo_r   : 8'h00;
   logic [7:0] rdata_r;

   // Read data is registered; unmapped addresses read zero.
   always_ff @(posedge core_clk or negedge nrst)
      if (!nrst)
      begin
         rdata_r  <= '0;
         cnt_lo_r <= '0;
         len_lo_r <= '0;
      end
      else if (reg_rd)
      begin
         rdata_r <= rd_mux;
         if (reg_addr == ADDR_LINES_HI) cnt_lo_r <= line_cnt_r[7:0];
         if (reg_addr == ADDR_LEN_HI)   len_lo_r <= line_len_r[7:0];
      end

   // Outputs straight from flip-flops.
   assign reg_rdata     = rdata_r;
   assign pin_state     = pin_r;
   assign tx0_data      = tx0_data_r;
   assign tx0_valid     = tx0_valid_r;
   assign tx1_data      = tx1_data_r;
   assign tx1_valid     = tx1_valid_r;
   assign tx1_clk_en    = tx1_clk_r;
   assign tx_lanes      = lanes_r;
   assign tx_rate       = rate_o_r;
   assign tx_timing     = tim_o_r;
   assign status_gpio   = pass_r;                                 // R15
   assign status_change = chg_r;

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sequence seq_repl_held;
      cfg_repl ##1 cfg_repl;
   endsequence
   sequence seq_start;
      fw_state_r == FW_IDLE ##1 fw_state_r == FW_SEND;
   endsequence

   chk_pd_hiz: assert property (!pd_s2_r |=> pin_state == PIN_HIZ) // R23
      else $error("power-down did not give high impedance");
   chk_sleep_hs0: assert property (pd_s2_r && !cfg_sleep |=> pin_state == PIN_HS0) // R7
      else $error("sleep select 0 did not give HS-0");
   chk_drive_hiz: assert property (pd_s2_r && cfg_sleep && !cfg_drive
      |=> pin_state == PIN_HIZ) // R8
      else $error("drive enable 0 did not give high impedance");
   chk_idle_hiz: assert property (pd_s2_r && cfg_sleep && cfg_drive && !any_active
      && !cfg_lp11 |=> pin_state == PIN_HIZ) // R10
      else $error("inactive ports did not give high impedance");
   chk_idle_lp11: assert property (pd_s2_r && cfg_sleep && cfg_drive
      && (any_active ? fwd_off : cfg_lp11) |=> pin_state == PIN_LP11) // R11
      else $error("expected LP-11 output");
   chk_repl_copy: assert property (seq_repl_held |-> tx1_data == tx0_data
      && tx1_valid == tx0_valid) // R4
      else $error("port 1 does not mirror port 0");
   chk_repl_clk: assert property (cfg_repl |=> tx1_clk_en) // R5
      else $error("second clock lane not enabled");
   chk_pass_flow: assert property (status_gpio |-> $past(fw_busy) && tx0_valid) // R13
      else $error("pass flag without data flowing");
   chk_sync_zero: assert property (!cfg_sync ##1 !cfg_sync |-> !sync_r) // R14
      else $error("sync flag set with synchronized forwarding off");
   chk_whole_pkt: assert property (seq_start |-> $past(pkt_cnt[pick]) != '0) // R17
      else $error("packet pulled before fully stored");
   chk_auto_time: assert property (!cfg_ovr && cfg_rate == RATE_800
      |=> tx_timing == TIM_800) // R2
      else $error("800M timing not loaded");
   chk_line_count: assert property (w0_end |=> line_cnt_r == $past(line_cnt_r) + 16'h0001) // R18
      else $error("line count did not advance");
endmodule

//--- logic/cstx_pkg.sv
// Constants and types shared by the transmitter output control block.
package cstx_pkg;
   // ----------------------------------------------------------------
   // Register offsets.
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_GEN_CFG   = 8'h02; // General output config.
   localparam logic [7:0] ADDR_RATE      = 8'h1f; // Lane rate select.
   localparam logic [7:0] ADDR_FWD_PORT  = 8'h20; // Forwarding port control.
   localparam logic [7:0] ADDR_FWD_MODE  = 8'h21; // Forwarding mode control.
   localparam logic [7:0] ADDR_TX_CTL    = 8'h33; // Transmitter control.
   localparam logic [7:0] ADDR_STATUS    = 8'h35; // Transmitter port status.
   localparam logic [7:0] ADDR_LINES_HI  = 8'h73; // Received lines, high byte.
   localparam logic [7:0] ADDR_LINES_LO  = 8'h74; // Received lines, low byte.
   localparam logic [7:0] ADDR_LEN_HI    = 8'h75; // Line bytes, high byte.
   localparam logic [7:0] ADDR_LEN_LO    = 8'h76; // Line bytes, low byte.
   localparam logic [7:0] ADDR_TIMING    = 8'hb0; // Programmed lane timing.
   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_GEN_CFG    = 8'h03;
   localparam logic [7:0] RST_FWD_PORT   = 8'h03;
   localparam logic [7:0] RST_ZERO       = 8'h00;
   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int B_SLEEP_SEL  = 0; // Sleep state select.
   localparam int B_PIN_DRIVE  = 1; // Pin drive enable.
   localparam int B_INACT_LP11 = 2; // Inactive output choice.
   localparam int B_OVERRIDE   = 7; // Timing override.
   localparam int B_REPLICATE  = 0; // Replicate mode.
   localparam int B_SYNC_FWD   = 1; // Synchronized forwarding.
   localparam int B_TX_EN      = 0; // Transmit enable.
   localparam int F_MAP_LO     = 0; // Port map, two bits.
   localparam int F_DIS_LO     = 4; // Per-port forward disable, two bits.
   localparam int F_LANES_LO   = 4; // Lane quantity, two bits.
   localparam int B_PASS       = 0; // Pass status.
   localparam int B_SYNC       = 1; // Sync status.
   // ----------------------------------------------------------------
   // Rate codes and automatic timing values (plain defaults).
   // ----------------------------------------------------------------
   localparam logic [1:0] RATE_1G6 = 2'h0;
   localparam logic [1:0] RATE_800 = 2'h2;
   localparam logic [1:0] RATE_400 = 2'h3;
   localparam logic [7:0] TIM_1G6  = 8'h20;
   localparam logic [7:0] TIM_800  = 8'h10;
   localparam logic [7:0] TIM_DFLT = 8'h08;
   // ----------------------------------------------------------------
   // Buffer geometry: 16 kB per receive port.
   // ----------------------------------------------------------------
   localparam int BUF_DEPTH = 16384;
   localparam int PTR_W     = 14;
   localparam int CNT_W     = 15;
   localparam int NPORT     = 2;
   // ----------------------------------------------------------------
   // Types.
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PIN_HIZ, PIN_HS0, PIN_LP11, PIN_VALID} cstx_pin_e;
   typedef enum logic {FW_IDLE, FW_SEND} cstx_fw_e;
endpackage

//--- verif/cstx_sink.sv
// Downstream video processor model that takes the forwarded bytes.
`timescale 1ns/10ps
module cstx_sink
(
   // Clock.
   input  wire logic       core_clk,
   // Lanes from the transmitter.
   input  wire logic [7:0] tx0_data,
   input  wire logic       tx0_valid,
   input  wire logic [7:0] tx1_data,
   input  wire logic       tx1_valid,
   // What was seen.
   output logic      [7:0] got_cnt,
   output logic      [7:0] got_last,
   output logic      [7:0] rep_cnt
);
   // --------------------------------------------------------------
   // Capture.
   // --------------------------------------------------------------
   // A copy counts only if it matches port 0 byte for byte.
   initial
   begin
      got_cnt = 8'h00;
      got_last = 8'h00;
      rep_cnt = 8'h00;
   end
   always @(posedge core_clk)
   begin
      if (tx0_valid === 1'b1)
      begin
         got_cnt <= got_cnt + 8'h01;
         got_last <= tx0_data;
      end
      if (tx1_valid === 1'b1 && tx1_data === tx0_data)
         rep_cnt <= rep_cnt + 8'h01;
   end
endmodule

//--- verif/test_csi2_tx_output_control.sv
// Self-checking bench for the transmitter output control block.
`timescale 1ns/10ps
module test_csi2_tx_output_control;
   import cstx_pkg::*;
   // --------------------------------------------------------------
   // Signals.
   // --------------------------------------------------------------
   logic            core_clk = 0, nrst = 0, pdn_n = 1, reg_wr = 0, reg_rd = 0;
   logic [1:0]      rx_lock = 0, rx_valid = 0, rx_last = 0, rx_err = 0, rx_ready;
   logic [7:0]      reg_addr = 0, reg_wdata = 0, reg_rdata, tx0_data, tx1_data, tx_timing;
   logic [1:0][7:0] rx_data = '0;
   logic [7:0]      got_cnt, got_last, rep_cnt, d;
   logic            pass_seen = 0, chg_seen = 0;
   logic            tx0_valid, tx1_valid, tx1_clk_en, status_gpio, status_change;
   logic [1:0]      tx_lanes, tx_rate;
   cstx_pin_e       pin_state;
   int              err_total = 0, checks_done = 0, k;
   always #2 core_clk = ~core_clk;
   cstx_out_ctl uut (.core_clk(core_clk), .nrst(nrst), .power_down_pin_n(pdn_n),
      .rx_lock(rx_lock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_last(rx_last), .rx_err(rx_err), .rx_ready(rx_ready), .pin_state(pin_state),
      .tx0_data(tx0_data), .tx0_valid(tx0_valid), .tx1_data(tx1_data),
      .tx1_valid(tx1_valid), .tx1_clk_en(tx1_clk_en), .tx_lanes(tx_lanes),
      .tx_rate(tx_rate), .tx_timing(tx_timing), .status_gpio(status_gpio),
      .status_change(status_change));
   cstx_sink sink (.core_clk(core_clk), .tx0_data(tx0_data), .tx0_valid(tx0_valid),
      .tx1_data(tx1_data), .tx1_valid(tx1_valid), .got_cnt(got_cnt),
      .got_last(got_last), .rep_cnt(rep_cnt));
   // --------------------------------------------------------------
   // Shared tasks.
   // --------------------------------------------------------------
   // Inputs always move 1 ns after the rising edge, clear of sampling.
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // Strobes drop for a cycle so no call re-raises them in one step.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_wr = 1;
      tick(1);
      reg_wr = 0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a);
      reg_addr = a;
      reg_rd = 1;
      tick(1);
      reg_rd = 0;
      d = reg_rdata;
      tick(1);
   endtask
   task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e)
      begin
         $display("Error %s expected %h seen %h", n, e, g);
         err_total++;
      end
   endtask
   task automatic cmpp(input string n, input cstx_pin_e e);
      checks_done++;
      if (pin_state !== e)
      begin
         $display("Error %s expected %0d seen %0d", n, e, pin_state);
         err_total++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // --------------------------------------------------------------
   // Scenarios.
   // --------------------------------------------------------------
   // Reset values, an unmapped read and output selection with no lock.
   task automatic t_pins;
      cmpp("pin_reset", PIN_HIZ);
      rd(ADDR_GEN_CFG);
      cmp8("gen_cfg", RST_GEN_CFG, d);
      rd(ADDR_FWD_PORT);
      cmp8("fwd_port", RST_FWD_PORT, d);
      rd(8'h40);
      cmp8("unmapped", 8'h00, d);
      wr(ADDR_GEN_CFG, 8'h02);
      cmpp("hs0", PIN_HS0);
      wr(ADDR_GEN_CFG, 8'h05);
      cmpp("no_drive", PIN_HIZ);
      wr(ADDR_GEN_CFG, 8'h07);
      cmpp("inact_lp11", PIN_LP11);
      pdn_n = 0;
      tick(5);
      cmpp("power_down", PIN_HIZ);
      pdn_n = 1;
      tick(5);
   endtask
   // Automatic timing per rate, then the host override at 400 Mbps.
   task automatic t_rate;
      wr(ADDR_RATE, {6'h00, RATE_1G6});
      cmp8("tim_1g6", TIM_1G6, tx_timing);
      wr(ADDR_RATE, {6'h00, RATE_800});
      cmp8("tim_800", TIM_800, tx_timing);
      wr(ADDR_RATE, 8'h01);
      cmp8("tim_dflt", TIM_DFLT, tx_timing);
      wr(ADDR_TIMING, 8'h55);
      wr(ADDR_RATE, 8'h83);
      cmp8("tim_400", 8'h55, tx_timing);
      cmp8("rate_400", {6'h00, RATE_400}, {6'h00, tx_rate});
   endtask
   // A packet held back until its last byte, replicated, then measured.
   task automatic t_fwd;
      wr(ADDR_TX_CTL, 8'h11);
      wr(ADDR_FWD_MODE, 8'h01);
      rx_lock = 2'b01;
      tick(5);
      cmpp("valid", PIN_VALID);
      cmp8("clk1", 8'h01, {7'h00, tx1_clk_en});
      cmp8("lanes", 8'h01, {6'h00, tx_lanes});
      for (k = 0; k < 4; k++)
      begin
         rx_valid[0] = 1;
         rx_data[0] = 8'ha0 + k[7:0];
         rx_last[0] = (k == 3);
         if (k == 3)
            cmp8("held", 8'h00, got_cnt);
         tick(1);
         // A gap before the last byte shows the partial packet held back.
         if (k == 2)
         begin
            rx_valid[0] = 0;
            tick(7);
         end
      end
      rx_valid[0] = 0;
      for (k = 0; k < 50 && got_cnt !== 8'h04; k++)
      begin
         tick(1);
         pass_seen = pass_seen | (status_gpio === 1'b1);
         chg_seen = chg_seen | (status_change === 1'b1);
      end
      cmp8("sent", 8'h04, got_cnt);
      cmp8("last", 8'ha3, got_last);
      cmp8("copies", 8'h04, rep_cnt);
      cmp8("pass", 8'h01, {7'h00, pass_seen});
      cmp8("change", 8'h01, {7'h00, chg_seen});
      rd(ADDR_STATUS);
      cmp8("sync", 8'h00, {7'h00, d[B_SYNC]});
      cmp8("pass_idle", 8'h00, {7'h00, d[B_PASS]});
      rd(ADDR_LINES_HI);
      cmp8("lines_hi", 8'h00, d);
      rd(ADDR_LINES_LO);
      cmp8("lines_lo", 8'h01, d);
      rd(ADDR_LEN_HI);
      cmp8("len_hi", 8'h00, d);
      rd(ADDR_LEN_LO);
      cmp8("len_lo", 8'h04, d);
      wr(ADDR_FWD_PORT, 8'h33);
      cmpp("fwd_dis", PIN_LP11);
   endtask
   // --------------------------------------------------------------
   // Main sequence.
   // --------------------------------------------------------------
   initial
   begin
      tick(8);
      nrst = 1;
      tick(5);
      t_pins();
      t_rate();
      t_fwd();
      if (got_cnt !== 8'h04)
         err_total++;
      test_done();
   end
endmodule
